// >>> inc/twu_pkg.sv
// Summary of operation
// RULE1: Enabled start request starts once bus free
// RULE2: After START set flag, status 08
// RULE3: Set flag suspends the serial transfer
// RULE4: Writing one clears flag; zero ignored
// RULE5: Status codes defined with prescaler bits zero
// RULE6: Address direction bit selects transmit or receive
// RULE7: Write bit and ACK low, read/NACK high
// RULE8: Eight data bits then receiver acknowledge bit
// RULE9: Data write while flag low discarded, collision
// RULE10: Software loads write address, clears flag
// RULE11: Address sent: status 18, 20 or 38
// RULE12: Data sent: status 28 or 30
// RULE13: Load byte, clear flag: send byte
// RULE14: Start request with flag clear: repeated START
// RULE15: Stop request sends STOP, hardware clears it
// RULE16: Both requests: STOP then START, stop cleared
// RULE17: In 10, address direction picks mode
// RULE18: In 38: release, or START when free
// RULE19: Repeated START keeps bus without STOP
// RULE20: Software keeps enable set during transfers
// RULE21: Software masks status with F8 first
// RULE22: Released high but sampled low: arbitration lost
// RULE23: Interrupt request while flag and irq enable
package twu_pkg;
  localparam logic [3:0] OFF_CTL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam int FLAG_BIT = 7;
  localparam int ACKEN_BIT = 6;
  localparam int START_BIT = 5;
  localparam int STOP_BIT = 4;
  localparam int WC_BIT = 3;
  localparam int EN_BIT = 2;
  localparam int IE_BIT = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam logic [7:0] ST_IDLE_CODE = 8'hF8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_SLAW_ACK = 8'h18;
  localparam logic [7:0] ST_SLAW_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_SLAR_ACK = 8'h40;
  localparam logic [7:0] ST_SLAR_NACK = 8'h48;
  localparam logic [7:0] CODE_MASK = 8'hF8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_NS = 40;
  localparam int QUARTER_NS = 80;
  localparam int QUARTER_CYC = ((QUARTER_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                               (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 8;
  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_WAIT_FREE = 12'h002,
    S_START_A = 12'h004,
    S_START_B = 12'h008,
    S_HOLD = 12'h010,
    S_BIT_LOW = 12'h020,
    S_BIT_HIGH = 12'h040,
    S_STOP_A = 12'h080,
    S_STOP_B = 12'h100,
    S_STOP_C = 12'h200,
    S_RS_A = 12'h400,
    S_RS_B = 12'h800
  } twu_state_e;
endpackage

// >>> src/twu_sync.sv
`timescale 1ns/1ps
module twu_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Lines idle high, so both stages reset to one
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else begin
        meta_q <= d[i];
        sync_q <= meta_q;
      end
    end
    assign q[i] = sync_q;
  end
endmodule // twu_sync

// >>> src/twu_tick.sv
`timescale 1ns/1ps
module twu_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic done
);
  localparam logic [twu_pkg::TICK_W-1:0] LAST = twu_pkg::TICK_W'(twu_pkg::QUARTER_CYC - 1);
  logic [twu_pkg::TICK_W-1:0] cnt_q;
  // Free-running quarter-bit period, realigned on every phase change
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign done = (cnt_q == LAST) && !restart;
endmodule // twu_tick

// >>> src/twu_master_tx.sv
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module twu_master_tx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  twu_pkg::twu_state_e st_q;
  twu_pkg::twu_state_e st_prev_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic flag_q, ack_en_q, start_q, stop_q, wc_q, en_q, ie_q;
  logic [7:0] code_q;
  logic [1:0] presc_q;
  logic [7:0] data_q;
  logic [7:0] shreg_q;
  logic [3:0] bitcnt_q;
  logic drv_q, half_q, addr_q, rw_q, mr_q, rep_q, busy_q, sda_p_q;
  logic scl_oe_q, sda_oe_q, irq_q, scl_o_q, sda_o_q;
  logic scl_s, sda_s, tick, restart;
  logic req, take, ctl_wr, dat_wr, stat_wr;
  logic bit_smp, arb_lost, byte_done, start_done, set_flag, clr_flag, ack_in;

  twu_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  // Phases that wait on a released clock line restart while it is held low
  assign restart = (st_q != st_prev_q) ||
                   (!scl_s && (st_q == twu_pkg::S_BIT_HIGH || st_q == twu_pkg::S_STOP_B ||
                               st_q == twu_pkg::S_RS_B));

  twu_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .restart(restart),
    .done(tick)
  );

  // Avalon slave: one wait cycle, request completes on the edge it sees waitrequest low
  assign req = avs_read || avs_write;
  assign take = req && !wait_q;
  assign ctl_wr = take && avs_write && avs_byteenable[0] && avs_address == twu_pkg::OFF_CTL;
  assign stat_wr = take && avs_write && avs_byteenable[0] && avs_address == twu_pkg::OFF_STAT;
  assign dat_wr = take && avs_write && avs_byteenable[0] && avs_address == twu_pkg::OFF_DATA;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (req && wait_q) begin
      unique case (avs_address)
        twu_pkg::OFF_CTL: rdata_q <= {24'h000000, flag_q, ack_en_q, start_q, stop_q,
                                      wc_q, en_q, 1'b0, ie_q};
        twu_pkg::OFF_STAT: rdata_q <= {24'h000000, code_q[7:3], 1'b0, presc_q}; // RULE5
        twu_pkg::OFF_DATA: rdata_q <= {24'h000000, data_q};
        default: rdata_q <= '0;
      endcase
    end
  end

  // Bus events seen on the synchronised lines
  assign bit_smp = (st_q == twu_pkg::S_BIT_HIGH) && tick;
  assign arb_lost = bit_smp && bitcnt_q != twu_pkg::BITS_PER_BYTE && !drv_q && !sda_s; // RULE22
  assign byte_done = bit_smp && bitcnt_q == twu_pkg::BITS_PER_BYTE; // RULE8
  assign ack_in = !sda_s; // RULE7
  assign start_done = (st_q == twu_pkg::S_START_B) && tick;
  assign set_flag = start_done || byte_done || arb_lost;
  assign clr_flag = ctl_wr && avs_writedata[twu_pkg::FLAG_BIT];

  // A hardware event in the same cycle as a software clear keeps the flag set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= twu_pkg::CTL_RESET[twu_pkg::FLAG_BIT];
    end else if (set_flag) begin
      flag_q <= 1'b1; // RULE2
    end else if (clr_flag) begin
      flag_q <= 1'b0; // RULE4
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_en_q <= twu_pkg::CTL_RESET[twu_pkg::ACKEN_BIT];
      start_q <= twu_pkg::CTL_RESET[twu_pkg::START_BIT];
      en_q <= twu_pkg::CTL_RESET[twu_pkg::EN_BIT];
      ie_q <= twu_pkg::CTL_RESET[twu_pkg::IE_BIT];
    end else if (ctl_wr) begin
      ack_en_q <= avs_writedata[twu_pkg::ACKEN_BIT];
      start_q <= avs_writedata[twu_pkg::START_BIT];
      en_q <= avs_writedata[twu_pkg::EN_BIT];
      ie_q <= avs_writedata[twu_pkg::IE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_q <= twu_pkg::CTL_RESET[twu_pkg::STOP_BIT];
    end else if (ctl_wr) begin
      stop_q <= avs_writedata[twu_pkg::STOP_BIT];
    end else if (st_q == twu_pkg::S_STOP_C && tick) begin
      stop_q <= 1'b0; // RULE15 RULE16
    end
  end

  // Data register only accepts writes while the flag is up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_q <= twu_pkg::DATA_RESET;
      wc_q <= twu_pkg::CTL_RESET[twu_pkg::WC_BIT];
    end else if (dat_wr) begin
      if (flag_q) begin
        data_q <= avs_writedata[7:0];
        wc_q <= 1'b0;
      end else begin
        wc_q <= 1'b1; // RULE9
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc_q <= 2'h0;
    end else if (stat_wr) begin
      presc_q <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      sda_p_q <= 1'b1;
    end else begin
      sda_p_q <= sda_s;
      if (scl_s && sda_p_q && !sda_s) begin
        busy_q <= 1'b1;
      end else if (scl_s && !sda_p_q && sda_s) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= twu_pkg::S_IDLE;
      st_prev_q <= twu_pkg::S_IDLE;
    end else begin
      st_prev_q <= st_q;
      if (!en_q) begin
        st_q <= twu_pkg::S_IDLE;
      end else begin
        unique case (st_q)
          twu_pkg::S_IDLE: if (!flag_q && start_q) st_q <= twu_pkg::S_WAIT_FREE; // RULE1 RULE18
          twu_pkg::S_WAIT_FREE: if (tick && !busy_q && scl_s && sda_s) begin
            st_q <= twu_pkg::S_START_A; // RULE1
          end
          twu_pkg::S_START_A: if (tick) st_q <= twu_pkg::S_START_B;
          twu_pkg::S_START_B: if (tick) st_q <= twu_pkg::S_HOLD;
          twu_pkg::S_HOLD: if (!flag_q) begin // RULE3
            if (stop_q) begin
              st_q <= twu_pkg::S_STOP_A; // RULE15 RULE16
            end else if (start_q) begin
              st_q <= twu_pkg::S_RS_A; // RULE14 RULE19
            end else if (addr_q || !mr_q) begin
              st_q <= twu_pkg::S_BIT_LOW; // RULE13
            end
          end
          twu_pkg::S_BIT_LOW: if (tick && half_q) st_q <= twu_pkg::S_BIT_HIGH;
          twu_pkg::S_BIT_HIGH: if (bit_smp) begin
            if (arb_lost) begin
              st_q <= twu_pkg::S_IDLE; // RULE22
            end else if (byte_done) begin
              st_q <= twu_pkg::S_HOLD; // RULE3
            end else begin
              st_q <= twu_pkg::S_BIT_LOW;
            end
          end
          twu_pkg::S_STOP_A: if (tick) st_q <= twu_pkg::S_STOP_B;
          twu_pkg::S_STOP_B: if (tick) st_q <= twu_pkg::S_STOP_C;
          twu_pkg::S_STOP_C: if (tick) begin
            st_q <= start_q ? twu_pkg::S_WAIT_FREE : twu_pkg::S_IDLE; // RULE16
          end
          twu_pkg::S_RS_A: if (tick) st_q <= twu_pkg::S_RS_B;
          twu_pkg::S_RS_B: if (tick) st_q <= twu_pkg::S_START_A; // RULE19
          default: st_q <= twu_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Shift path; data changes a quarter period after the clock line falls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shreg_q <= '0;
      bitcnt_q <= '0;
      drv_q <= 1'b0;
      half_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (st_q == twu_pkg::S_START_B) begin
      drv_q <= 1'b1;
    end else if (st_q == twu_pkg::S_HOLD && !flag_q && !stop_q && !start_q) begin
      shreg_q <= data_q; // RULE10 RULE13
      bitcnt_q <= '0;
      half_q <= 1'b0;
      if (addr_q) begin
        rw_q <= data_q[0]; // RULE6
      end
    end else if (st_q == twu_pkg::S_BIT_LOW && tick && !half_q) begin
      drv_q <= (bitcnt_q != twu_pkg::BITS_PER_BYTE) && !shreg_q[7]; // RULE7 RULE8
      half_q <= 1'b1;
    end else if (bit_smp && !byte_done && !arb_lost) begin
      shreg_q <= {shreg_q[6:0], 1'b0};
      bitcnt_q <= bitcnt_q + 4'h1;
      half_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_q <= twu_pkg::ST_IDLE_CODE;
      addr_q <= 1'b0;
      mr_q <= 1'b0;
      rep_q <= 1'b0;
    end else if (start_done) begin
      code_q <= rep_q ? twu_pkg::ST_RSTART : twu_pkg::ST_START; // RULE2 RULE14
      addr_q <= 1'b1;
      rep_q <= 1'b0;
    end else if (arb_lost) begin
      code_q <= twu_pkg::ST_ARB_LOST; // RULE11 RULE22
      addr_q <= 1'b0;
      mr_q <= 1'b0;
    end else if (byte_done) begin
      addr_q <= 1'b0;
      if (addr_q && rw_q) begin
        code_q <= ack_in ? twu_pkg::ST_SLAR_ACK : twu_pkg::ST_SLAR_NACK; // RULE17
        mr_q <= 1'b1; // RULE6
      end else if (addr_q) begin
        code_q <= ack_in ? twu_pkg::ST_SLAW_ACK : twu_pkg::ST_SLAW_NACK; // RULE11
        mr_q <= 1'b0; // RULE6
      end else begin
        code_q <= ack_in ? twu_pkg::ST_DATA_ACK : twu_pkg::ST_DATA_NACK; // RULE12
      end
    end else if (st_q == twu_pkg::S_RS_A) begin
      rep_q <= 1'b1;
    end else if (st_q == twu_pkg::S_STOP_C && tick) begin
      code_q <= twu_pkg::ST_IDLE_CODE;
      mr_q <= 1'b0;
    end
  end

  // Open-drain drive: enable pulls low, the pad level is always zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      irq_q <= flag_q && ie_q; // RULE23
      unique case (st_q)
        twu_pkg::S_HOLD, twu_pkg::S_BIT_LOW: begin
          scl_oe_q <= 1'b1; // RULE3
          sda_oe_q <= drv_q;
        end
        twu_pkg::S_BIT_HIGH: begin
          scl_oe_q <= 1'b0;
          sda_oe_q <= drv_q;
        end
        twu_pkg::S_START_A, twu_pkg::S_STOP_B: begin
          scl_oe_q <= 1'b0;
          sda_oe_q <= 1'b1;
        end
        twu_pkg::S_START_B, twu_pkg::S_STOP_A: begin
          scl_oe_q <= 1'b1;
          sda_oe_q <= 1'b1;
        end
        twu_pkg::S_RS_A: begin
          scl_oe_q <= 1'b1;
          sda_oe_q <= 1'b0;
        end
        default: begin
          scl_oe_q <= 1'b0; // RULE18
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign scl_o = scl_o_q;
  assign sda_o = sda_o_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  start_go_a: assert property (st_q == twu_pkg::S_IDLE && en_q && start_q && !flag_q
    |=> st_q == twu_pkg::S_WAIT_FREE) else $error("start request not taken"); // RULE1
  start_code_a: assert property (start_done |=> flag_q &&
    (code_q == twu_pkg::ST_START || code_q == twu_pkg::ST_RSTART))
    else $error("start status wrong"); // RULE2
  hold_still_a: assert property (st_q == twu_pkg::S_HOLD && flag_q && en_q
    |=> st_q == twu_pkg::S_HOLD ##1 scl_oe_q) else $error("transfer not held"); // RULE3
  flag_clear_a: assert property (clr_flag && !set_flag |=> !flag_q)
    else $error("flag not cleared"); // RULE4
  code_mask_a: assert property ((code_q & ~twu_pkg::CODE_MASK) == 8'h00)
    else $error("status low bits set"); // RULE5
  collide_a: assert property (dat_wr && !flag_q |=> wc_q && $stable(data_q))
    else $error("collision write not discarded"); // RULE9
  addr_code_a: assert property (byte_done && addr_q && !rw_q |=>
    code_q == ($past(ack_in) ? twu_pkg::ST_SLAW_ACK : twu_pkg::ST_SLAW_NACK) && flag_q)
    else $error("address status wrong"); // RULE11
  data_code_a: assert property (byte_done && !addr_q |=>
    code_q == ($past(ack_in) ? twu_pkg::ST_DATA_ACK : twu_pkg::ST_DATA_NACK) && flag_q)
    else $error("data status wrong"); // RULE12
  rstart_go_a: assert property (st_q == twu_pkg::S_HOLD && en_q && !flag_q && start_q && !stop_q
    |=> st_q == twu_pkg::S_RS_A) else $error("repeated start not taken"); // RULE14
  stop_clear_a: assert property (st_q == twu_pkg::S_STOP_C && tick && !ctl_wr && en_q
    |=> !stop_q ##[1:4] !scl_oe_q && !sda_oe_q) else $error("stop not finished"); // RULE15
  arb_release_a: assert property (arb_lost |=> code_q == twu_pkg::ST_ARB_LOST
    ##1 !scl_oe_q && !sda_oe_q) else $error("arbitration loss not handled"); // RULE22
  irq_follow_a: assert property (flag_q && ie_q |=> irq) else $error("irq missing"); // RULE23

  start_c: cover property (start_done);
  data_ack_c: cover property (byte_done && !addr_q && ack_in);
  arb_c: cover property (arb_lost);
  stop_c: cover property (st_q == twu_pkg::S_STOP_C && tick);
endmodule // twu_master_tx

// >>> tb/twu_slave_model.sv
`timescale 1ns/1ps
module twu_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic steal,
  input wire logic stretch,
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] last_byte,
  output int starts,
  output int stops
);
  int bit_cnt;
  logic [7:0] sh;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    starts = 0;
    stops = 0;
    bit_cnt = 0;
  end
  // Start and stop only count while the clock line is high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      starts++;
      bit_cnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stops++;
      bit_cnt = 0;
    end
  end
  always @(posedge scl) begin
    if (bit_cnt < 8) sh = {sh[6:0], sda};
    if (bit_cnt == 7) last_byte = sh;
    bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
  end
  // Ack is a low level; a competing master pulls data low while the device sends
  always @(negedge scl) begin
    sda_low = (bit_cnt == 8 && !nack) || (steal && bit_cnt < 8);
  end
  always @(negedge steal) begin
    sda_low = 1'b0;
  end
  // A slow receiver holds the clock low after each falling edge
  always @(negedge scl) begin
    if (stretch) begin
      scl_low = 1'b1;
      #1000 scl_low = 1'b0;
    end
  end
endmodule // twu_slave_model

// >>> tb/tb_twu_master_tx.sv
`timescale 1ns/1ps
module tb_twu_master_tx;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, scl_o, scl_oe, sda_o, sda_oe, irq, scl_low, sda_low;
  logic nack = 1'b0;
  logic steal = 1'b0;
  logic stretch = 1'b0;
  logic [7:0] last_byte, rd, b;
  int starts, stops, s0, t0;
  int error_cnt = 0;
  int check_count = 0;
  // Both lines have pull-ups: released means high
  wire scl_w = !(scl_oe | scl_low);
  wire sda_w = !(sda_oe | sda_low);

  twu_master_tx twu_master_tx_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq(irq));
  twu_slave_model twu_slave_model_inst (.scl(scl_w), .sda(sda_w), .nack(nack),
    .steal(steal), .stretch(stretch), .scl_low(scl_low), .sda_low(sda_low),
    .last_byte(last_byte), .starts(starts), .stops(stops));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata[7:0];
    if (avs_waitrequest !== 1'b0) chk("waitrequest", 8'h00, 8'h01);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic poll(input int bitn, input logic v);
    int n;
    n = 0;
    do begin
      bus(twu_pkg::OFF_CTL, 1'b0, 8'h00);
      n++;
    end while (rd[bitn] !== v && n < 300);
    chk("control bit", {7'h0, v}, {7'h0, rd[bitn]});
  endtask

  task automatic step(input logic [7:0] ctl, input logic [7:0] exp);
    bus(twu_pkg::OFF_CTL, 1'b1, ctl);
    poll(twu_pkg::FLAG_BIT, 1'b1);
    chk("irq", {7'h0, ctl[twu_pkg::IE_BIT]}, {7'h0, irq});
    bus(twu_pkg::OFF_STAT, 1'b0, 8'h00);
    chk("status", exp, rd & twu_pkg::CODE_MASK);
  endtask

  function automatic logic [7:0] exp_code(input bit adr, input logic [7:0] v, input logic nk);
    if (adr && v[0]) return nk ? twu_pkg::ST_SLAR_NACK : twu_pkg::ST_SLAR_ACK;
    if (adr) return nk ? twu_pkg::ST_SLAW_NACK : twu_pkg::ST_SLAW_ACK;
    return nk ? twu_pkg::ST_DATA_NACK : twu_pkg::ST_DATA_ACK;
  endfunction

  task automatic send(input bit adr, input logic [7:0] v, input logic nk);
    nack <= nk;
    bus(twu_pkg::OFF_DATA, 1'b1, v);
    step(8'h85, exp_code(adr, v, nk));
    chk("byte on wire", v, last_byte);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles; this only cuts a hang
  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h04B1200B));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(twu_pkg::OFF_CTL, 1'b0, 8'h00);
    chk("control reset", twu_pkg::CTL_RESET, rd);
    bus(twu_pkg::OFF_STAT, 1'b0, 8'h00);
    chk("status reset", twu_pkg::ST_IDLE_CODE, rd);
    bus(4'hC, 1'b0, 8'h00);
    chk("unmapped read", 8'h00, rd);
    bus(twu_pkg::OFF_DATA, 1'b1, 8'h5A);
    bus(twu_pkg::OFF_DATA, 1'b0, 8'h00);
    chk("data after collision", twu_pkg::DATA_RESET, rd);
    bus(twu_pkg::OFF_CTL, 1'b0, 8'h00);
    chk("collision bit", 8'h08, rd & 8'h08);
    bus(twu_pkg::OFF_STAT, 1'b1, 8'h03);
    bus(twu_pkg::OFF_STAT, 1'b0, 8'h00);
    chk("prescaler bits", twu_pkg::ST_IDLE_CODE | 8'h03, rd);
    step(8'hA4, twu_pkg::ST_START);
    repeat (60) @(posedge clk);
    chk("clock held low", 8'h01, {7'h0, scl_oe});
    bus(twu_pkg::OFF_CTL, 1'b1, 8'h04);
    bus(twu_pkg::OFF_CTL, 1'b0, 8'h00);
    chk("flag kept", 8'h80, rd & 8'h80);
    b = 8'($urandom);
    b[0] = 1'b0;
    send(1'b1, b, 1'b0);
    for (int i = 0; i < 6; i++) begin
      send(1'b0, 8'($urandom), 1'($urandom));
    end
    send(1'b0, 8'hFF, 1'b1);
    send(1'b0, 8'h00, 1'b0);
    stretch <= 1'b1;
    send(1'b0, 8'($urandom), 1'b0);
    stretch <= 1'b0;
    s0 = stops;
    t0 = starts;
    step(8'hA5, twu_pkg::ST_RSTART);
    chk("no stop on restart", 8'(s0), 8'(stops));
    chk("restart on wire", 8'(t0 + 1), 8'(starts));
    send(1'b1, b | 8'h01, 1'b1);
    step(8'hA5, twu_pkg::ST_RSTART);
    send(1'b1, b, 1'b0);
    s0 = stops;
    t0 = starts;
    step(8'hB5, twu_pkg::ST_START);
    chk("stop then start", 8'(s0 + 1), 8'(stops));
    chk("start after stop", 8'(t0 + 1), 8'(starts));
    bus(twu_pkg::OFF_CTL, 1'b0, 8'h00);
    chk("stop request cleared", 8'h00, rd & 8'h10);
    send(1'b1, b, 1'b1);
    send(1'b0, 8'($urandom), 1'b0);
    s0 = stops;
    bus(twu_pkg::OFF_CTL, 1'b1, 8'h94);
    poll(twu_pkg::STOP_BIT, 1'b0);
    chk("stop on wire", 8'(s0 + 1), 8'(stops));
    chk("no flag after stop", 8'h00, rd & 8'h80);
    bus(twu_pkg::OFF_STAT, 1'b0, 8'h00);
    chk("idle status", twu_pkg::ST_IDLE_CODE, rd & twu_pkg::CODE_MASK);
    for (int k = 0; k < 2; k++) begin
      // Second pass starts from an owned bus, so the start is a repeated one
      step(8'hA4, (k == 0) ? twu_pkg::ST_START : twu_pkg::ST_RSTART);
      steal <= 1'b1;
      bus(twu_pkg::OFF_DATA, 1'b1, 8'hFE);
      step(8'h84, twu_pkg::ST_ARB_LOST);
      chk("lines free on loss", 8'h00, {4'h0, scl_o, sda_o, scl_oe, sda_oe});
      steal <= 1'b0;
      if (k == 0) begin
        step(8'hA4, twu_pkg::ST_START);
      end else begin
        bus(twu_pkg::OFF_CTL, 1'b1, 8'h84);
        repeat (40) @(posedge clk);
        bus(twu_pkg::OFF_CTL, 1'b0, 8'h00);
        chk("released", 8'h00, {rd[7], 5'h0, scl_oe, sda_oe});
      end
    end
    print_verdict();
  end
endmodule // tb_twu_master_tx
